//--- core_sfr_dual_data_pointer.sv
// Core register set with dual data pointers behind an AXI4-Lite slave
module core_sfr_dual_data_pointer
(
  input  wire logic                            clk_i,
  input  wire logic                            nrst_i,
  input  wire logic [core_sfr_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                            s_axi_awvalid_i,
  output logic                                 s_axi_awready_o,
  input  wire logic [31:0]                     s_axi_wdata_i,
  input  wire logic [3:0]                      s_axi_wstrb_i,
  input  wire logic                            s_axi_wvalid_i,
  output logic                                 s_axi_wready_o,
  output logic [1:0]                           s_axi_bresp_o,
  output logic                                 s_axi_bvalid_o,
  input  wire logic                            s_axi_bready_i,
  input  wire logic [core_sfr_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                            s_axi_arvalid_i,
  output logic                                 s_axi_arready_o,
  output logic [31:0]                          s_axi_rdata_o,
  output logic [1:0]                           s_axi_rresp_o,
  output logic                                 s_axi_rvalid_o,
  input  wire logic                            s_axi_rready_i,
  output logic [15:0]                          instr_counter_o,
  output logic [1:0]                           bank_select_o
);

  typedef struct packed {
    logic [7:0]  stack_top_pointer;
    logic [7:0]  pointer_select_reg;
    logic [7:0]  program_status_word;
    logic [7:0]  primary_operand_reg;
    logic [7:0]  aux_operand_reg;
    logic [15:0] data_ptr_zero;
    logic [15:0] data_ptr_one;
    logic [15:0] instr_counter;
    logic [15:0] last_addr;
    logic        aw_got;
    logic [7:0]  aw_idx;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

  localparam state_t ST_RST = '{
    stack_top_pointer:   core_sfr_pkg::STACK_RST,
    pointer_select_reg:  core_sfr_pkg::PSEL_RST,
    program_status_word: core_sfr_pkg::PSW_RST,
    primary_operand_reg: core_sfr_pkg::PRIM_RST,
    aux_operand_reg:     core_sfr_pkg::AUX_RST,
    data_ptr_zero:       core_sfr_pkg::PTR_RST,
    data_ptr_one:        core_sfr_pkg::PTR_RST,
    instr_counter:       core_sfr_pkg::PC_RST,
    last_addr:           core_sfr_pkg::PTR_RST,
    aw_got:              1'b0,
    aw_idx:              8'h00,
    w_got:               1'b0,
    wdata:               32'h00000000,
    wstrb:               4'h0,
    awready:             1'b0,
    wready:              1'b0,
    bvalid:              1'b0,
    bresp:               core_sfr_pkg::RESP_OKAY,
    arready:             1'b0,
    rvalid:              1'b0,
    rdata:               32'h00000000,
    rresp:               core_sfr_pkg::RESP_OKAY
  };

  state_t      st_reg;
  state_t      st_next;
  logic        wr_go;
  logic        cmd_fire;
  logic [2:0]  cmd_op;
  logic        cin;
  logic [8:0]  sum9;
  logic [4:0]  sum_nib;
  logic [8:0]  dif9;
  logic [4:0]  dif_nib;
  logic [15:0] product;
  logic [15:0] ptr0_stepped;
  logic [15:0] ptr1_stepped;
  logic        sel_now;
  logic [7:0]  psw_view;
  logic [32:0] rd_word;
  logic [32:0] wr_word;

  // Read view of a word: bit 32 marks a mapped index
  function automatic logic [32:0] read_word(input state_t s, input logic [7:0] idx, input logic [7:0] psw_v);
    logic [32:0] r;
    r = 33'h000000000;
    unique case (idx)
      core_sfr_pkg::IDX_STACK:   r = {1'b1, 24'h000000, s.stack_top_pointer};
      core_sfr_pkg::IDX_PSEL:    r = {1'b1, 24'h000000, s.pointer_select_reg & core_sfr_pkg::PSEL_MASK};
      core_sfr_pkg::IDX_PSW:     r = {1'b1, 24'h000000, psw_v};
      core_sfr_pkg::IDX_PRIM:    r = {1'b1, 24'h000000, s.primary_operand_reg};
      core_sfr_pkg::IDX_AUX:     r = {1'b1, 24'h000000, s.aux_operand_reg};
      core_sfr_pkg::IDX_P0_LOW:  r = {1'b1, 24'h000000, s.data_ptr_zero[7:0]};
      core_sfr_pkg::IDX_P0_HIGH: r = {1'b1, 24'h000000, s.data_ptr_zero[15:8]};
      core_sfr_pkg::IDX_P1_LOW:  r = {1'b1, 24'h000000, s.data_ptr_one[7:0]};
      core_sfr_pkg::IDX_P1_HIGH: r = {1'b1, 24'h000000, s.data_ptr_one[15:8]};
      core_sfr_pkg::IDX_CMD:     r = {1'b1, 32'h00000000};
      core_sfr_pkg::IDX_PC:      r = {1'b1, 16'h0000, s.instr_counter};
      core_sfr_pkg::IDX_LAST:    r = {1'b1, 16'h0000, s.last_addr};
      default:                   r = 33'h000000000;
    endcase
    return r;
  endfunction : read_word

  ptr_step u_step_zero
  (
    .ptr_i  (st_reg.data_ptr_zero),
    .down_i (st_reg.pointer_select_reg[core_sfr_pkg::SD0_BIT]),
    .ptr_o  (ptr0_stepped)
  );

  ptr_step u_step_one
  (
    .ptr_i  (st_reg.data_ptr_one),
    .down_i (st_reg.pointer_select_reg[core_sfr_pkg::SD1_BIT]),
    .ptr_o  (ptr1_stepped)
  );

  assign wr_go    = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
  assign cmd_fire = wr_go && (st_reg.aw_idx == core_sfr_pkg::IDX_CMD) && st_reg.wstrb[0];
  assign cmd_op   = st_reg.wdata[2:0];
  assign cin      = st_reg.wdata[core_sfr_pkg::CMD_CIN_BIT] && st_reg.program_status_word[core_sfr_pkg::CARRY_BIT];
  assign sel_now  = st_reg.pointer_select_reg[core_sfr_pkg::SEL_BIT];
  assign product  = 16'(st_reg.primary_operand_reg) * 16'(st_reg.aux_operand_reg);
  assign sum9     = {1'b0, st_reg.primary_operand_reg} + {1'b0, st_reg.aux_operand_reg} + {8'h00, cin};
  assign sum_nib  = {1'b0, st_reg.primary_operand_reg[3:0]} + {1'b0, st_reg.aux_operand_reg[3:0]} + {4'h0, cin};
  assign dif9     = {1'b0, st_reg.primary_operand_reg} - {1'b0, st_reg.aux_operand_reg} - {8'h00, cin};
  assign dif_nib  = {1'b0, st_reg.primary_operand_reg[3:0]} - {1'b0, st_reg.aux_operand_reg[3:0]} - {4'h0, cin};
  // Parity follows the primary register at all times, the stored bit is never shown
  assign psw_view = {st_reg.program_status_word[7:1], ^st_reg.primary_operand_reg};
  assign rd_word  = read_word(st_reg, s_axi_araddr_i[core_sfr_pkg::ADDR_W-1:2], psw_view);
  assign wr_word  = read_word(st_reg, st_reg.aw_idx, psw_view);

  always_comb
  begin
    st_next = st_reg;
    if (s_axi_awvalid_i && st_reg.awready)
    begin
      st_next.aw_got = 1'b1;
      st_next.aw_idx = s_axi_awaddr_i[core_sfr_pkg::ADDR_W-1:2];
    end
    if (s_axi_wvalid_i && st_reg.wready)
    begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata_i;
      st_next.wstrb = s_axi_wstrb_i;
    end
    if (st_reg.bvalid && s_axi_bready_i)
    begin
      st_next.bvalid = 1'b0;
    end
    if (wr_go)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = wr_word[32] ? core_sfr_pkg::RESP_OKAY : core_sfr_pkg::RESP_SLVERR;
      if (st_reg.wstrb[0])
      begin
        unique case (st_reg.aw_idx)
          core_sfr_pkg::IDX_STACK:   st_next.stack_top_pointer = st_reg.wdata[7:0];
          core_sfr_pkg::IDX_PSEL:    st_next.pointer_select_reg = st_reg.wdata[7:0] & core_sfr_pkg::PSEL_MASK;
          core_sfr_pkg::IDX_PSW:     st_next.program_status_word = st_reg.wdata[7:0];
          core_sfr_pkg::IDX_PRIM:    st_next.primary_operand_reg = st_reg.wdata[7:0];
          core_sfr_pkg::IDX_AUX:     st_next.aux_operand_reg = st_reg.wdata[7:0];
          core_sfr_pkg::IDX_P0_LOW:  st_next.data_ptr_zero[7:0] = st_reg.wdata[7:0];
          core_sfr_pkg::IDX_P0_HIGH: st_next.data_ptr_zero[15:8] = st_reg.wdata[7:0];
          core_sfr_pkg::IDX_P1_LOW:  st_next.data_ptr_one[7:0] = st_reg.wdata[7:0];
          core_sfr_pkg::IDX_P1_HIGH: st_next.data_ptr_one[15:8] = st_reg.wdata[7:0];
          default:                   st_next.stack_top_pointer = st_reg.stack_top_pointer;
        endcase
      end
    end
    if (cmd_fire)
    begin
      unique case (cmd_op)
        core_sfr_pkg::OP_MUL:
        begin
          st_next.primary_operand_reg = product[7:0];
          st_next.aux_operand_reg     = product[15:8];
          st_next.program_status_word[core_sfr_pkg::CARRY_BIT]  = 1'b0;
          st_next.program_status_word[core_sfr_pkg::SIGNED_BIT] = |product[15:8];
        end
        core_sfr_pkg::OP_DIV:
        begin
          st_next.program_status_word[core_sfr_pkg::CARRY_BIT] = 1'b0;
          // Divide by zero leaves both operands and flags the signed-range bit
          if (st_reg.aux_operand_reg == 8'h00)
          begin
            st_next.program_status_word[core_sfr_pkg::SIGNED_BIT] = 1'b1;
          end
          else
          begin
            st_next.primary_operand_reg = st_reg.primary_operand_reg / st_reg.aux_operand_reg;
            st_next.aux_operand_reg     = st_reg.primary_operand_reg % st_reg.aux_operand_reg;
            st_next.program_status_word[core_sfr_pkg::SIGNED_BIT] = 1'b0;
          end
        end
        core_sfr_pkg::OP_ADD:
        begin
          st_next.primary_operand_reg = sum9[7:0];
          st_next.program_status_word[core_sfr_pkg::CARRY_BIT]  = sum9[8];
          st_next.program_status_word[core_sfr_pkg::HALF_BIT]   = sum_nib[4];
          st_next.program_status_word[core_sfr_pkg::SIGNED_BIT] =
            (st_reg.primary_operand_reg[7] == st_reg.aux_operand_reg[7]) &&
            (sum9[7] != st_reg.primary_operand_reg[7]);
        end
        core_sfr_pkg::OP_SUB:
        begin
          st_next.primary_operand_reg = dif9[7:0];
          st_next.program_status_word[core_sfr_pkg::CARRY_BIT]  = dif9[8];
          st_next.program_status_word[core_sfr_pkg::HALF_BIT]   = dif_nib[4];
          st_next.program_status_word[core_sfr_pkg::SIGNED_BIT] =
            (st_reg.primary_operand_reg[7] != st_reg.aux_operand_reg[7]) &&
            (dif9[7] != st_reg.primary_operand_reg[7]);
        end
        core_sfr_pkg::OP_PTR_ACC:
        begin
          // Step uses the select bit as it stood for this access, toggle applies to the next
          st_next.last_addr = sel_now ? st_reg.data_ptr_one : st_reg.data_ptr_zero;
          if (!sel_now && st_reg.pointer_select_reg[core_sfr_pkg::AS0_BIT])
          begin
            st_next.data_ptr_zero = ptr0_stepped;
          end
          if (sel_now && st_reg.pointer_select_reg[core_sfr_pkg::AS1_BIT])
          begin
            st_next.data_ptr_one = ptr1_stepped;
          end
          st_next.pointer_select_reg[core_sfr_pkg::SEL_BIT] =
            sel_now ^ st_reg.pointer_select_reg[core_sfr_pkg::TGL_BIT];
        end
        core_sfr_pkg::OP_PTR_INC:
        begin
          st_next.data_ptr_one  = sel_now ? st_reg.data_ptr_one + 16'h0001 : st_reg.data_ptr_one;
          st_next.data_ptr_zero = sel_now ? st_reg.data_ptr_zero : st_reg.data_ptr_zero + 16'h0001;
        end
        core_sfr_pkg::OP_PC_STEP: st_next.instr_counter = st_reg.instr_counter + 16'h0001;
        default:                  st_next.instr_counter = st_reg.instr_counter;
      endcase
    end
    if (st_reg.rvalid && s_axi_rready_i)
    begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && st_reg.arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_word[31:0];
      st_next.rresp  = rd_word[32] ? core_sfr_pkg::RESP_OKAY : core_sfr_pkg::RESP_SLVERR;
    end
    st_next.awready = !st_next.aw_got && !st_next.bvalid;
    st_next.wready  = !st_next.w_got && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      st_reg <= ST_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready_o = st_reg.awready;
  assign s_axi_wready_o  = st_reg.wready;
  assign s_axi_bvalid_o  = st_reg.bvalid;
  assign s_axi_bresp_o   = st_reg.bresp;
  assign s_axi_arready_o = st_reg.arready;
  assign s_axi_rvalid_o  = st_reg.rvalid;
  assign s_axi_rdata_o   = st_reg.rdata;
  assign s_axi_rresp_o   = st_reg.rresp;
  assign instr_counter_o = st_reg.instr_counter;
  // Working bank base is this pair followed by three zero bits
  assign bank_select_o   = st_reg.program_status_word[core_sfr_pkg::BANK_HI_BIT:core_sfr_pkg::BANK_LO_BIT];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  logic       do_add;
  logic       ptr_acc;
  logic [8:0] chk_sum;
  logic [4:0] chk_nib;
  assign do_add  = cmd_fire && (cmd_op == core_sfr_pkg::OP_ADD);
  assign ptr_acc = cmd_fire && (cmd_op == core_sfr_pkg::OP_PTR_ACC);
  assign chk_sum = 9'(st_reg.primary_operand_reg) + 9'(st_reg.aux_operand_reg) + 9'(cin);
  assign chk_nib = 5'(st_reg.primary_operand_reg[3:0]) + 5'(st_reg.aux_operand_reg[3:0]) + 5'(cin);

  sequence psw_read_s;
    s_axi_arvalid_i && s_axi_arready_o && (s_axi_araddr_i[core_sfr_pkg::ADDR_W-1:2] == core_sfr_pkg::IDX_PSW);
  endsequence
  sequence write_taken_s;
    st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
  endsequence
  pc_reset_a: assert property (!$past(nrst_i) |-> instr_counter_o == 16'h0000)
    else $error("counter not zero after reset");
  stack_reset_a: assert property (!$past(nrst_i) |-> st_reg.stack_top_pointer == 8'h07)
    else $error("stack pointer not 07 after reset");
  status_reset_a: assert property (!$past(nrst_i) |-> st_reg.program_status_word == 8'h00)
    else $error("status word not clear after reset");
  select_reset_a: assert property (!$past(nrst_i) |-> (s_axi_awready_o == 1'b0) ##0
    (st_reg.pointer_select_reg & 8'hF9) == 8'h00)
    else $error("pointer select not clear after reset");
  mul_product_a: assert property (cmd_fire && cmd_op == core_sfr_pkg::OP_MUL |=>
    {st_reg.aux_operand_reg, st_reg.primary_operand_reg} ==
    16'($past(st_reg.primary_operand_reg)) * 16'($past(st_reg.aux_operand_reg)))
    else $error("multiply result wrong");
  div_result_a: assert property (cmd_fire && cmd_op == core_sfr_pkg::OP_DIV && st_reg.aux_operand_reg != 8'h00 |=>
    st_reg.primary_operand_reg == $past(st_reg.primary_operand_reg) / $past(st_reg.aux_operand_reg) &&
    st_reg.aux_operand_reg == $past(st_reg.primary_operand_reg) % $past(st_reg.aux_operand_reg))
    else $error("divide result wrong");
  add_carry_a: assert property (do_add |=> st_reg.program_status_word[7] == $past(chk_sum[8]))
    else $error("carry flag wrong after add");
  half_carry_a: assert property (do_add |=> st_reg.program_status_word[6] == $past(chk_nib[4]))
    else $error("half carry wrong after add");
  parity_read_a: assert property (psw_read_s |=> s_axi_rvalid_o &&
    s_axi_rdata_o[0] == ^$past(st_reg.primary_operand_reg))
    else $error("parity bit does not follow primary register");
  ptr_zero_step_a: assert property (ptr_acc && !sel_now && st_reg.pointer_select_reg[3] |=>
    st_reg.data_ptr_zero == ($past(st_reg.pointer_select_reg[6]) ? $past(st_reg.data_ptr_zero) - 16'h0001
                                                                 : $past(st_reg.data_ptr_zero) + 16'h0001))
    else $error("pointer zero step wrong");
  ptr_one_step_a: assert property (ptr_acc && sel_now && st_reg.pointer_select_reg[4] |=>
    st_reg.data_ptr_one == ($past(st_reg.pointer_select_reg[7]) ? $past(st_reg.data_ptr_one) - 16'h0001
                                                                : $past(st_reg.data_ptr_one) + 16'h0001))
    else $error("pointer one step wrong");
  select_toggle_a: assert property (ptr_acc |=>
    st_reg.pointer_select_reg[0] == ($past(sel_now) ^ $past(st_reg.pointer_select_reg[5])))
    else $error("select bit toggle wrong");
  write_answer_a: assert property (write_taken_s |=> s_axi_bvalid_o [*1] ##0 !s_axi_awready_o)
    else $error("write response missing");

endmodule : core_sfr_dual_data_pointer

//--- core_sfr_pkg.sv
// Constants shared by the core register set: word indices, bit positions, reset values, commands
package core_sfr_pkg;

  localparam int          ADDR_W      = 10;

  // Word indices; the byte address is four times the index
  localparam logic [7:0]  IDX_CMD     = 8'h10;
  localparam logic [7:0]  IDX_PC      = 8'h11;
  localparam logic [7:0]  IDX_LAST    = 8'h12;
  localparam logic [7:0]  IDX_STACK   = 8'h81;
  localparam logic [7:0]  IDX_P0_LOW  = 8'h82;
  localparam logic [7:0]  IDX_P0_HIGH = 8'h83;
  localparam logic [7:0]  IDX_P1_LOW  = 8'h84;
  localparam logic [7:0]  IDX_P1_HIGH = 8'h85;
  localparam logic [7:0]  IDX_PSEL    = 8'h86;
  localparam logic [7:0]  IDX_PSW     = 8'hD0;
  localparam logic [7:0]  IDX_PRIM    = 8'hE0;
  localparam logic [7:0]  IDX_AUX     = 8'hF0;

  // Reset values
  localparam logic [15:0] PC_RST      = 16'h0000;
  localparam logic [7:0]  STACK_RST   = 8'h07;
  localparam logic [7:0]  PSEL_RST    = 8'h00;
  localparam logic [7:0]  PSW_RST     = 8'h00;
  localparam logic [7:0]  PRIM_RST    = 8'h00;
  localparam logic [7:0]  AUX_RST     = 8'h00;
  localparam logic [15:0] PTR_RST     = 16'h0000;

  // Status word bit positions
  localparam int          CARRY_BIT   = 7;
  localparam int          HALF_BIT    = 6;
  localparam int          BANK_HI_BIT = 4;
  localparam int          BANK_LO_BIT = 3;
  localparam int          SIGNED_BIT  = 2;
  localparam int          PARITY_BIT  = 0;

  // Pointer select bit positions; bits 2 and 1 are reserved
  localparam int          SD1_BIT     = 7;
  localparam int          SD0_BIT     = 6;
  localparam int          TGL_BIT     = 5;
  localparam int          AS1_BIT     = 4;
  localparam int          AS0_BIT     = 3;
  localparam int          SEL_BIT     = 0;
  localparam logic [7:0]  PSEL_MASK   = 8'hF9;

  // Command word: operation in bits 2..0, carry-in enable in bit 3
  localparam int          CMD_CIN_BIT = 3;
  localparam logic [2:0]  OP_MUL      = 3'h1;
  localparam logic [2:0]  OP_DIV      = 3'h2;
  localparam logic [2:0]  OP_ADD      = 3'h3;
  localparam logic [2:0]  OP_SUB      = 3'h4;
  localparam logic [2:0]  OP_PTR_ACC  = 3'h5;
  localparam logic [2:0]  OP_PTR_INC  = 3'h6;
  localparam logic [2:0]  OP_PC_STEP  = 3'h7;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : core_sfr_pkg

//--- ptr_step.sv
// One-step increment or decrement of a 16-bit data pointer
module ptr_step
(
  input  wire logic [15:0] ptr_i,
  input  wire logic        down_i,
  output logic      [15:0] ptr_o
);

  assign ptr_o = down_i ? (ptr_i - 16'h0001) : (ptr_i + 16'h0001);

endmodule : ptr_step

//--- tb_top.sv
// Self-checking bench for the core register set with dual data pointers
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 0, nrst_i = 0;
  logic [9:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, bank;
  logic [15:0] pc_o, pc = '0, last = '0;
  logic [15:0] p [2] = '{default: 16'h0000};
  logic [7:0]  m [256] = '{default: 8'h00};
  logic [7:0]  idx [12] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'hD0, 8'hE0, 8'hF0, 8'h10, 8'h11, 8'h12};
  int          n_fail = 0, n_checks = 0;

  core_sfr_dual_data_pointer DUT
  (
    .clk_i(clk_i), .nrst_i(nrst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .instr_counter_o(pc_o), .bank_select_o(bank)
  );

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  function automatic logic [31:0] exp_of(input logic [7:0] i);
    case (i)
      8'h11: return {16'h0, pc};
      8'h12: return {16'h0, last};
      8'h82, 8'h83, 8'h84, 8'h85: return {24'h0, p[i[2]][i[0]*8 +: 8]};
      8'hD0: return {24'h0, m[8'hD0][7:1], ^m[8'hE0]};
      8'h81, 8'h86, 8'hE0, 8'hF0: return {24'h0, m[i]};
      default: return 32'h0;
    endcase
  endfunction : exp_of

  // Reference behaviour of one command word
  task automatic mop(input logic [7:0] d);
    logic [15:0] r;
    logic [4:0]  h;
    logic [7:0]  a, b, f;
    logic        c, s;
    a = m[8'hE0];
    b = m[8'hF0];
    f = m[8'hD0];
    c = d[3] & f[7];
    s = m[8'h86][0];
    case (d[2:0])
      3'h1:
      begin
        r = a * b;
        {m[8'hF0], m[8'hE0]} = r;
        f[7] = 1'b0;
        f[2] = |r[15:8];
      end
      3'h2:
      begin
        f[7] = 1'b0;
        f[2] = (b == 8'h00);
        if (b != 8'h00)
          {m[8'hF0], m[8'hE0]} = {a % b, a / b};
      end
      3'h3, 3'h4:
      begin
        r = d[2] ? a - b - c : a + b + c;
        h = d[2] ? a[3:0] - b[3:0] - c : a[3:0] + b[3:0] + c;
        f[7] = r[8];
        f[6] = h[4];
        f[2] = ((a[7] ^ b[7]) == d[2]) && (r[7] != a[7]);
        m[8'hE0] = r[7:0];
      end
      3'h5:
      begin
        last = p[s];
        if (m[8'h86][3 + s])
          p[s] = m[8'h86][6 + s] ? p[s] - 16'h1 : p[s] + 16'h1;
        m[8'h86][0] = s ^ m[8'h86][5];
      end
      3'h6: p[s] = p[s] + 16'h1;
      3'h7: pc = pc + 16'h1;
      default: ;
    endcase
    m[8'hD0] = f;
  endtask : mop

  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
    int         t;
    logic [1:0] r;
    @(posedge clk_i);
    awaddr <= {i, 2'($urandom)};
    wdata <= {24'($urandom), d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    t = 0;
    r = 2'h3;
    do
    begin
      @(posedge clk_i);
      t++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        r = bresp;
      end
    end while (r == 2'h3 && t < 50);
    chk({30'h0, r}, {30'h0, er});
    if (er == 2'h0)
      case (i)
        8'h82, 8'h83, 8'h84, 8'h85: p[i[2]][i[0]*8 +: 8] = d;
        8'h86: m[i] = d & 8'hF9;
        8'h81, 8'hD0, 8'hE0, 8'hF0: m[i] = d;
        8'h10: mop(d);
        default: ;
      endcase
  endtask : wr

  task automatic rd(input logic [7:0] i, input logic [1:0] er);
    int          t;
    logic [1:0]  r;
    logic [31:0] v;
    @(posedge clk_i);
    araddr <= {i, 2'($urandom)};
    arvalid <= 1'b1;
    rready <= 1'b1;
    t = 0;
    r = 2'h3;
    do
    begin
      @(posedge clk_i);
      t++;
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        r = rresp;
        v = rdata;
      end
    end while (r == 2'h3 && t < 50);
    chk(v, exp_of(i));
    chk({30'h0, r}, {30'h0, er});
  endtask : rd

  task automatic chk_all;
    foreach (idx[k])
      rd(idx[k], 2'h0);
    chk({16'h0, pc_o}, {16'h0, pc});
    chk({30'h0, bank}, {30'h0, m[8'hD0][4:3]});
  endtask : chk_all

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (30000) @(posedge clk_i);
    n_fail++;
    close_out;
  end

  initial
  begin
    void'($urandom(20514));
    m[8'h81] = 8'h07;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk_all;
    rd(8'h00, 2'h2);
    wr(8'h3F, 8'hFF, 2'h2);
    wr(8'h11, 8'h55, 2'h0);
    wr(8'h86, 8'hFF, 2'h0);
    // Command code zero must leave every register alone
    wr(8'h10, 8'h08, 2'h0);
    chk_all;
    for (int k = 0; k < 40; k++)
    begin
      wr(8'hD0, 8'($urandom), 2'h0);
      wr(8'hE0, 8'($urandom), 2'h0);
      wr(8'hF0, k == 0 ? 8'h00 : 8'($urandom), 2'h0);
      wr(8'h10, {4'h0, 1'($urandom), 3'((k + 1) % 4 + 1)}, 2'h0);
      chk_all;
    end
    for (int k = 0; k < 40; k++)
    begin
      wr(8'h86, 8'($urandom), 2'h0);
      if (k % 4 == 0)
        for (int j = 2; j < 6; j++)
          wr(8'(128 + j), k % 8 == 0 ? 8'hFF : 8'($urandom), 2'h0);
      wr(8'h10, k % 5 == 4 ? 8'h06 : 8'h05, 2'h0);
      wr(8'h10, 8'h05, 2'h0);
      chk_all;
    end
    repeat (3) wr(8'h10, 8'h07, 2'h0);
    chk_all;
    // Second reset from a busy state: every register must return to its reset value
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    m = '{default: 8'h00};
    m[8'h81] = 8'h07;
    p = '{default: 16'h0000};
    pc = 16'h0000;
    last = 16'h0000;
    repeat (2) @(posedge clk_i);
    chk_all;
    close_out;
  end
endmodule : tb_top
